// >>> common/udb_map.vh
// timing constants and counts for the ultra dma burst handshake block
`ifndef UDB_MAP_VH
`define UDB_MAP_VH

// ------------------------------------------------------------
// clock
// ------------------------------------------------------------
`define UDB_CLK_NS 20
// least times round up to whole cycles, never below one
`define UDB_UP(ns) ((((ns) + `UDB_CLK_NS - 1) / `UDB_CLK_NS) < 1 ? 1 : \
  (((ns) + `UDB_CLK_NS - 1) / `UDB_CLK_NS))

// ------------------------------------------------------------
// mode-dependent least times in ns, modes 0 to 4, then tDVH, one value for all modes
// ------------------------------------------------------------
`define UDB_TCYC_NS_M0 120
`define UDB_TCYC_NS_M1 80
`define UDB_TCYC_NS_M2 60
`define UDB_TCYC_NS_M3 40
`define UDB_TCYC_NS_M4 40
`define UDB_TDVS_NS_M0 80
`define UDB_TDVS_NS_M1 60
`define UDB_TDVS_NS_M2 40
`define UDB_TDVS_NS_M3 20
`define UDB_TDVS_NS_M4 20
`define UDB_TDVH_NS 20

// ------------------------------------------------------------
// mode-independent least times in ns
// ------------------------------------------------------------
`define UDB_TZIORDY_NS 20
`define UDB_TZAD_NS 20
`define UDB_TACK_NS 20

// ------------------------------------------------------------
// counts in clock cycles
// ------------------------------------------------------------
`define UDB_TCYC_M0 `UDB_UP(`UDB_TCYC_NS_M0)
`define UDB_TCYC_M1 `UDB_UP(`UDB_TCYC_NS_M1)
`define UDB_TCYC_M2 `UDB_UP(`UDB_TCYC_NS_M2)
`define UDB_TCYC_M3 `UDB_UP(`UDB_TCYC_NS_M3)
`define UDB_TCYC_M4 `UDB_UP(`UDB_TCYC_NS_M4)
`define UDB_TDVS_M0 `UDB_UP(`UDB_TDVS_NS_M0)
`define UDB_TDVS_M1 `UDB_UP(`UDB_TDVS_NS_M1)
`define UDB_TDVS_M2 `UDB_UP(`UDB_TDVS_NS_M2)
`define UDB_TDVS_M3 `UDB_UP(`UDB_TDVS_NS_M3)
`define UDB_TDVS_M4 `UDB_UP(`UDB_TDVS_NS_M4)
`define UDB_TDVH `UDB_UP(`UDB_TDVH_NS)
`define UDB_TZIORDY `UDB_UP(`UDB_TZIORDY_NS)
`define UDB_TZAD `UDB_UP(`UDB_TZAD_NS)
`define UDB_TACK `UDB_UP(`UDB_TACK_NS)

// ------------------------------------------------------------
// crc
// ------------------------------------------------------------
`define UDB_CRC_SEED 16'h4aba
`define UDB_CRC_POLY 16'h1021

`endif

// >>> logic/udb_crc16.v
// 16-bit crc accumulator, one word per enable
`timescale 1ns/1ps
`include "udb_map.vh"

module udb_crc16 #(
  parameter [15:0] SEED = `UDB_CRC_SEED,
  parameter [15:0] POLY = `UDB_CRC_POLY
) (
  input wire clk,
  input wire rst_n,
  input wire init,
  input wire en,
  input wire [15:0] data,
  output reg [15:0] crc_q
);

  reg [15:0] crc_d;
  integer i;

  // data enters msb first, one bit per step
  always @* begin
    crc_d = crc_q;
    for (i = 15; i >= 0; i = i - 1) begin
      if (crc_d[15] ^ data[i]) begin
        crc_d = {crc_d[14:0], 1'b0} ^ POLY;
      end else begin
        crc_d = {crc_d[14:0], 1'b0};
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 16'h0000;
    end else if (init) begin
      crc_q <= SEED;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end

endmodule

// >>> logic/udb_burst.v
// device end of ultra dma data-in and data-out bursts
//
// What this block does
// - stop strobing once host ready negates
// - drop request within tLI of stop, keep low
// - raise low strobe after stop, carries no data
// - release data bus when request drops
// - latch host crc on acknowledge negation
// - compare crc per burst, report first error
// - release strobe line after acknowledge negation
// - device starts data-out burst with request
// - drive ready negated tZIORDY after acknowledge
// - assert ready after stop drops, hold it
// - seed crc every burst before data moves
`timescale 1ns/1ps
`include "udb_map.vh"

module udb_burst #(
  parameter CW = 8
) (
  input wire CLK_SYS,
  input wire RESET_N,
  input wire [2:0] MODE,
  input wire IN_REQ,
  input wire OUT_REQ,
  input wire CMD_DONE,
  input wire [15:0] TX_DATA,
  input wire TX_VALID,
  output reg TX_READY,
  output reg [15:0] RX_DATA,
  output reg RX_VALID,
  output reg BURST_DONE,
  output reg CRC_ERR,
  output reg [7:0] CRC_ERR_BURST,
  input wire DMACK_N,
  input wire STOP,
  input wire HOST_STB,
  input wire [15:0] D_IN,
  output reg [15:0] D_OUT,
  output reg D_OE_N,
  output reg DMARQ,
  output reg DEV_STB_OUT,
  output reg DEV_STB_OE_N
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_IN_REQ = 3'd1;
  localparam [2:0] S_IN_RUN = 3'd2;
  localparam [2:0] S_IN_END = 3'd3;
  localparam [2:0] S_OUT_REQ = 3'd4;
  localparam [2:0] S_OUT_RUN = 3'd5;
  localparam [2:0] S_OUT_END = 3'd6;
  localparam [2:0] S_GAP = 3'd7;

  localparam [31:0] C_DVH = `UDB_TDVH;
  localparam [31:0] C_ZIORDY = `UDB_TZIORDY;
  localparam [31:0] C_ZAD = `UDB_TZAD;
  localparam [31:0] C_ACK = `UDB_TACK;
  localparam [CW-1:0] C_MAX = {CW{1'b1}};

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] ack_s_q;
  reg [1:0] stop_s_q;
  reg [2:0] hstb_s_q;
  reg [15:0] d_s1_q;
  reg [15:0] d_s2_q;

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_s_q <= 3'h7;
      stop_s_q <= 2'h0;
      hstb_s_q <= 3'h7;
      d_s1_q <= 16'h0000;
      d_s2_q <= 16'h0000;
    end else begin
      ack_s_q <= {ack_s_q[1:0], DMACK_N};
      stop_s_q <= {stop_s_q[0], STOP};
      hstb_s_q <= {hstb_s_q[1:0], HOST_STB};
      d_s1_q <= D_IN;
      d_s2_q <= d_s1_q;
    end
  end

  wire dmack = ~ack_s_q[1];
  wire ack_rise = ack_s_q[1] & ~ack_s_q[2];
  wire stop = stop_s_q[1];
  // the host strobe pin carries ready (active low) during data-in
  wire hrdy = ~hstb_s_q[1];
  wire hstb_edge = hstb_s_q[1] ^ hstb_s_q[2];

  // ------------------------------------------------------------
  // mode-dependent timing
  // ------------------------------------------------------------
  reg [31:0] c_cyc;
  reg [31:0] c_dvs;

  always @* begin
    case (MODE)
      3'd0: begin
        c_cyc = `UDB_TCYC_M0;
        c_dvs = `UDB_TDVS_M0;
      end
      3'd1: begin
        c_cyc = `UDB_TCYC_M1;
        c_dvs = `UDB_TDVS_M1;
      end
      3'd2: begin
        c_cyc = `UDB_TCYC_M2;
        c_dvs = `UDB_TDVS_M2;
      end
      3'd3: begin
        c_cyc = `UDB_TCYC_M3;
        c_dvs = `UDB_TDVS_M3;
      end
      default: begin
        c_cyc = `UDB_TCYC_M4;
        c_dvs = `UDB_TDVS_M4;
      end
    endcase
  end

  // ------------------------------------------------------------
  // crc
  // ------------------------------------------------------------
  reg crc_init_q;
  reg crc_en_q;
  reg [15:0] crc_word_q;
  wire [15:0] crc_val;

  udb_crc16 u_crc (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .init(crc_init_q),
    .en(crc_en_q),
    .data(crc_word_q),
    .crc_q(crc_val)
  );

  // ------------------------------------------------------------
  // burst state machine
  // ------------------------------------------------------------
  reg [2:0] st_q;
  reg [CW-1:0] ecnt_q;
  reg [CW-1:0] lcnt_q;
  reg have_q;
  reg err_seen_q;
  reg [7:0] err_burst_q;
  reg [7:0] burst_cnt_q;
  reg chk_q;
  reg [15:0] crc_rx_q;

  wire [CW-1:0] ecnt_inc = (ecnt_q == C_MAX) ? ecnt_q : ecnt_q + 1'b1;
  wire [CW-1:0] lcnt_inc = (lcnt_q == C_MAX) ? lcnt_q : lcnt_q + 1'b1;
  wire miss = chk_q && (crc_rx_q != crc_val);

  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= S_IDLE;
      ecnt_q <= {CW{1'b0}};
      lcnt_q <= {CW{1'b0}};
      have_q <= 1'b0;
      DMARQ <= 1'b0;
      D_OUT <= 16'h0000;
      D_OE_N <= 1'b1;
      DEV_STB_OUT <= 1'b1;
      DEV_STB_OE_N <= 1'b1;
      TX_READY <= 1'b0;
      RX_DATA <= 16'h0000;
      RX_VALID <= 1'b0;
      BURST_DONE <= 1'b0;
      crc_init_q <= 1'b0;
      crc_en_q <= 1'b0;
      crc_word_q <= 16'h0000;
      chk_q <= 1'b0;
      crc_rx_q <= 16'h0000;
    end else begin
      TX_READY <= 1'b0;
      RX_VALID <= 1'b0;
      BURST_DONE <= 1'b0;
      crc_init_q <= 1'b0;
      crc_en_q <= 1'b0;
      chk_q <= 1'b0;
      ecnt_q <= ecnt_inc;
      lcnt_q <= lcnt_inc;
      case (st_q)
        S_IDLE: begin
          ecnt_q <= {CW{1'b0}};
          if (!dmack && (IN_REQ || OUT_REQ)) begin
            crc_init_q <= 1'b1;
            DMARQ <= 1'b1;
            st_q <= IN_REQ ? S_IN_REQ : S_OUT_REQ;
          end
        end
        S_IN_REQ: begin
          if (!dmack) begin
            ecnt_q <= {CW{1'b0}};
          end else if (DEV_STB_OE_N && ecnt_q >= C_ZIORDY[CW-1:0]) begin
            DEV_STB_OE_N <= 1'b0;
            DEV_STB_OUT <= 1'b1;
          end
          if (DEV_STB_OE_N || stop || !hrdy) begin
            lcnt_q <= {CW{1'b0}};
          end else if (lcnt_q >= C_ZAD[CW-1:0] && TX_VALID) begin
            // first word goes out, strobe may fall after tDVS
            D_OUT <= TX_DATA;
            D_OE_N <= 1'b0;
            have_q <= 1'b1;
            lcnt_q <= {CW{1'b0}};
            ecnt_q <= c_cyc[CW-1:0];
            st_q <= S_IN_RUN;
          end
        end
        S_IN_RUN: begin
          if (stop) begin
            DMARQ <= 1'b0;
            D_OE_N <= 1'b1;
            DEV_STB_OUT <= 1'b1;
            have_q <= 1'b0;
            st_q <= S_IN_END;
          end else if (have_q && hrdy && lcnt_q >= c_dvs[CW-1:0] &&
                       ecnt_q >= c_cyc[CW-1:0]) begin
            // the word counts as taken only once it is strobed
            DEV_STB_OUT <= ~DEV_STB_OUT;
            TX_READY <= 1'b1;
            crc_en_q <= 1'b1;
            crc_word_q <= D_OUT;
            have_q <= 1'b0;
            ecnt_q <= {CW{1'b0}};
          end else if (!have_q && hrdy && TX_VALID &&
                       ecnt_q >= C_DVH[CW-1:0]) begin
            D_OUT <= TX_DATA;
            have_q <= 1'b1;
            lcnt_q <= {CW{1'b0}};
          end
        end
        S_IN_END: begin
          if (ack_rise) begin
            crc_rx_q <= d_s2_q;
            chk_q <= 1'b1;
            DEV_STB_OE_N <= 1'b1;
            ecnt_q <= {CW{1'b0}};
            st_q <= S_GAP;
          end
        end
        S_OUT_REQ: begin
          if (!dmack) begin
            ecnt_q <= {CW{1'b0}};
          end else if (DEV_STB_OE_N) begin
            if (ecnt_q >= C_ZIORDY[CW-1:0]) begin
              DEV_STB_OE_N <= 1'b0;
              DEV_STB_OUT <= 1'b1;
            end
          end else if (!stop) begin
            DEV_STB_OUT <= 1'b0;
            st_q <= S_OUT_RUN;
          end
        end
        S_OUT_RUN: begin
          if (stop) begin
            DMARQ <= 1'b0;
            DEV_STB_OUT <= 1'b1;
            st_q <= S_OUT_END;
          end else if (hstb_edge) begin
            // data sampled alongside the strobe, held by tDVH
            RX_DATA <= d_s2_q;
            RX_VALID <= 1'b1;
            crc_en_q <= 1'b1;
            crc_word_q <= d_s2_q;
          end
        end
        S_OUT_END: begin
          // the strobe rise forced by termination is ignored here
          if (ack_rise) begin
            crc_rx_q <= d_s2_q;
            chk_q <= 1'b1;
            DEV_STB_OE_N <= 1'b1;
            ecnt_q <= {CW{1'b0}};
            st_q <= S_GAP;
          end
        end
        S_GAP: begin
          if (ecnt_q == {CW{1'b0}}) begin
            BURST_DONE <= 1'b1;
          end
          if (ecnt_q >= C_ACK[CW-1:0]) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // crc error tracking per command
  // ------------------------------------------------------------
  always @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      err_seen_q <= 1'b0;
      err_burst_q <= 8'h00;
      burst_cnt_q <= 8'h00;
      CRC_ERR <= 1'b0;
      CRC_ERR_BURST <= 8'h00;
    end else if (CMD_DONE) begin
      // a miscompare landing in the same cycle still counts
      CRC_ERR <= err_seen_q | miss;
      CRC_ERR_BURST <= err_seen_q ? err_burst_q : burst_cnt_q;
      err_seen_q <= 1'b0;
      err_burst_q <= 8'h00;
      burst_cnt_q <= 8'h00;
    end else if (chk_q) begin
      burst_cnt_q <= burst_cnt_q + 8'h01;
      if (miss && !err_seen_q) begin
        err_seen_q <= 1'b1;
        err_burst_q <= burst_cnt_q;
      end
    end
  end

endmodule

// >>> tb/udb_burst_checker.sv
// port assertions for the ultra dma burst block
`timescale 1ns/1ps
module udb_burst_checker #(
  parameter CW = 8
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic IN_REQ,
  input wire logic OUT_REQ,
  input wire logic DMACK_N,
  input wire logic STOP,
  input wire logic HOST_STB,
  input wire logic DMARQ,
  input wire logic D_OE_N,
  input wire logic DEV_STB_OUT,
  input wire logic DEV_STB_OE_N,
  input wire logic RX_VALID,
  input wire logic BURST_DONE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  wire run = !DMACK_N && DMARQ;
  wire outm = OUT_REQ && !IN_REQ;
  AST_RQ_DROP: assert property ($rose(STOP) && run |-> ##[1:4] !DMARQ)
    else $error("request held after stop");
  AST_RQ_LOW: assert property (!DMARQ && STOP && !DMACK_N |=> !DMARQ)
    else $error("request raised inside termination");
  AST_STB_HI: assert property ($rose(STOP) && run |->
    ##[1:4] (DEV_STB_OUT && !DMARQ) ##1 DEV_STB_OUT [*3])
    else $error("device strobe not parked high");
  AST_QUIET: assert property ($rose(HOST_STB) && run && IN_REQ |->
    ##4 $stable(DEV_STB_OUT) [*4])
    else $error("strobe still moving after ready negated");
  AST_BUS_OWN: assert property (!D_OE_N |-> DMARQ && !DMACK_N)
    else $error("data bus driven outside data-in run");
  AST_DONE: assert property ($rose(DMACK_N) && !DMARQ |->
    ##[1:6] BURST_DONE)
    else $error("no burst end after acknowledge negation");
  AST_STB_REL: assert property ($rose(DMACK_N) |-> ##[1:4] DEV_STB_OE_N)
    else $error("strobe pin not released");
  AST_ZIORDY: assert property ($fell(DMACK_N) |-> DEV_STB_OE_N [*2])
    else $error("strobe pin driven too early");
  AST_RDY_KEEP: assert property (!DEV_STB_OE_N && !DMACK_N |=>
    !DEV_STB_OE_N)
    else $error("strobe pin released inside burst");
  AST_RDY_ON: assert property ($fell(STOP) && run && outm |->
    ##[1:5] !DEV_STB_OUT)
    else $error("ready not asserted after stop negation");
  AST_RX: assert property ($changed(HOST_STB) && run && !STOP && outm
    |-> ##[2:3] RX_VALID)
    else $error("host strobe edge not captured");
  cover property (BURST_DONE && IN_REQ);
  cover property (BURST_DONE && OUT_REQ);
  cover property (RX_VALID ##4 RX_VALID);
endmodule

// >>> tb/udb_host_model.sv
// host side model of the ultra dma burst pins
`timescale 1ns/1ps
module udb_host_model (
  input wire logic clk,
  input wire logic dmarq,
  input wire logic dstb,
  input wire logic [15:0] d,
  output logic dmack_n,
  output logic stop,
  output logic hstb,
  output logic hen,
  output logic [15:0] hd
);
  logic [15:0] crc;
  logic [15:0] got[$];
  logic sl;
  int gap;
  int mgap;
  function automatic logic [15:0] nx(logic [15:0] c, logic [15:0] w);
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0);
    return c;
  endfunction
  initial begin
    dmack_n = 1;
    stop = 0;
    hstb = 1;
    hen = 0;
    hd = 16'h0;
  end
  task automatic open(input logic r);
    while (!dmarq) @(negedge clk);
    stop = 1;
    hstb = 1;
    crc = 16'h4aba;
    repeat (2) @(negedge clk);
    dmack_n = 0;
    repeat (6) @(negedge clk);
    stop = 0;
    hstb = r;
  endtask
  // data-in words count on every level change the host sees on the strobe pin, pull-up included
  task automatic smp;
    @(negedge clk);
    gap++;
    if (dstb !== sl) begin
      sl = dstb;
      got.push_back(d);
      crc = nx(crc, d);
      // the first edge has no predecessor, so it gives no spacing
      if (gap > 0 && gap < mgap) mgap = gap;
      gap = 0;
    end
  endtask
  task automatic din(input int n);
    got.delete();
    open(0);
    sl = 1;
    mgap = 99;
    gap = -99;
    while (got.size() < n) smp();
    hstb = 1;
    repeat (8) smp();
  endtask
  task automatic dout(input int n, input logic [15:0] b);
    open(1);
    repeat (6) @(negedge clk);
    hen = 1;
    for (int k = 0; k < n; k++) begin
      hd = b + 16'(k);
      crc = nx(crc, hd);
      repeat (2) @(negedge clk);
      hstb = ~hstb;
      repeat (2) @(negedge clk);
    end
  endtask
  task automatic close(input logic bad);
    stop = 1;
    repeat (6) @(negedge clk);
    hstb = 1;
    hen = 1;
    hd = crc ^ {15'h0, bad};
    repeat (4) @(negedge clk);
    dmack_n = 1;
    repeat (3) @(negedge clk);
    stop = 0;
    hen = 0;
  endtask
endmodule

// >>> tb/udb_burst_tb_top.sv
// self-checking bench for the ultra dma burst block
`timescale 1ns/1ps
`include "udb_map.vh"
module udb_burst_tb_top;
  logic CLK_SYS = 0;
  logic RESET_N = 0;
  logic [2:0] MODE = 3'h4;
  logic IN_REQ = 0;
  logic OUT_REQ = 0;
  logic CMD_DONE = 0;
  logic TX_VALID = 1;
  logic [15:0] txk = 16'h0;
  wire [15:0] TX_DATA = 16'h1000 + txk;
  wire TX_READY, RX_VALID, BURST_DONE, CRC_ERR, D_OE_N, DMARQ;
  wire DEV_STB_OUT, DEV_STB_OE_N, DMACK_N, STOP, HOST_STB, hen;
  wire [15:0] RX_DATA, D_OUT, D_IN, hd;
  wire [7:0] CRC_ERR_BURST;
  // released lines: strobe pin has a pull-up, data bus floats away
  wire dstb = DEV_STB_OE_N ? 1'b1 : DEV_STB_OUT;
  assign D_IN = !D_OE_N ? D_OUT : hen ? hd : ~hd;
  logic [15:0] rxq[$];
  int mismatches = 0;
  int check_count = 0;
  udb_burst u_dut (
    .CLK_SYS(CLK_SYS),
    .RESET_N(RESET_N),
    .MODE(MODE),
    .IN_REQ(IN_REQ),
    .OUT_REQ(OUT_REQ),
    .CMD_DONE(CMD_DONE),
    .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID),
    .TX_READY(TX_READY),
    .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID),
    .BURST_DONE(BURST_DONE),
    .CRC_ERR(CRC_ERR),
    .CRC_ERR_BURST(CRC_ERR_BURST),
    .DMACK_N(DMACK_N),
    .STOP(STOP),
    .HOST_STB(HOST_STB),
    .D_IN(D_IN),
    .D_OUT(D_OUT),
    .D_OE_N(D_OE_N),
    .DMARQ(DMARQ),
    .DEV_STB_OUT(DEV_STB_OUT),
    .DEV_STB_OE_N(DEV_STB_OE_N)
  );
  udb_host_model u_h (.clk(CLK_SYS), .dmarq(DMARQ), .dstb(dstb),
    .d(D_IN), .dmack_n(DMACK_N), .stop(STOP), .hstb(HOST_STB),
    .hen(hen), .hd(hd));
  initial forever #10 CLK_SYS = ~CLK_SYS;
  always @(negedge CLK_SYS) if (TX_READY === 1'b1) txk <= txk + 16'h1;
  always @(posedge CLK_SYS) if (RX_VALID === 1'b1) rxq.push_back(RX_DATA);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wdone;
    int k;
    k = 0;
    while (BURST_DONE !== 1'b1 && k < 40) begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    chk("burst_done", 16'h1, {15'h0, BURST_DONE});
    @(negedge CLK_SYS);
  endtask
  task automatic cmd(input logic e, input logic [7:0] ix);
    CMD_DONE = 1;
    @(negedge CLK_SYS);
    CMD_DONE = 0;
    repeat (2) @(negedge CLK_SYS);
    chk("crc_err", {15'h0, e}, {15'h0, CRC_ERR});
    if (e) chk("err_burst", {8'h0, ix}, {8'h0, CRC_ERR_BURST});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_din(input logic [2:0] m);
    logic [15:0] b;
    int tc;
    case (m)
      3'h0: tc = `UDB_TCYC_M0;
      3'h1: tc = `UDB_TCYC_M1;
      3'h2: tc = `UDB_TCYC_M2;
      3'h3: tc = `UDB_TCYC_M3;
      default: tc = `UDB_TCYC_M4;
    endcase
    MODE = m;
    b = txk;
    IN_REQ = 1;
    u_h.din(4);
    IN_REQ = 0;
    fork
      u_h.close(1'b0);
      wdone();
    join
    chk("words", txk - b, 16'(u_h.got.size()));
    // ready drops right after the fourth word, before any further strobe
    chk("din_count", 16'h4, 16'(u_h.got.size()));
    foreach (u_h.got[i])
      chk("din_word", 16'h1000 + b + 16'(i), u_h.got[i]);
    chk("gap_ok", 16'h1, {15'h0, u_h.mgap >= tc});
    cmd(1'b0, 8'h0);
    $display("test din mode %0d done", m);
  endtask
  task automatic t_dout(input int nb, input logic [2:0] bad,
    input logic e, input logic [7:0] ix);
    logic [15:0] b;
    for (int j = 0; j < nb; j++) begin
      b = 16'h2000 + 16'(j * 16);
      rxq.delete();
      OUT_REQ = 1;
      u_h.dout(5, b);
      if (j == nb - 1) OUT_REQ = 0;
      fork
        u_h.close(bad[j]);
        wdone();
      join
      chk("rx_count", 16'h5, 16'(rxq.size()));
      foreach (rxq[i]) chk("rx_word", b + 16'(i), rxq[i]);
    end
    cmd(e, ix);
    $display("test dout %0d bursts done", nb);
  endtask
  initial begin
    repeat (10) @(negedge CLK_SYS);
    RESET_N = 1;
    @(negedge CLK_SYS);
    t_din(3'h0);
    t_din(3'h1);
    t_din(3'h2);
    t_din(3'h3);
    // mode 4 last: the host strobe spacing in t_dout suits it
    t_din(3'h4);
    t_dout(3, 3'b110, 1'b1, 8'h1);
    t_dout(1, 3'b000, 1'b0, 8'h0);
    report_and_stop;
  end
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
endmodule
bind udb_burst udb_burst_checker #(.CW(CW)) u_chk (
  .CLK_SYS(CLK_SYS),
  .RESET_N(RESET_N),
  .IN_REQ(IN_REQ),
  .OUT_REQ(OUT_REQ),
  .DMACK_N(DMACK_N),
  .STOP(STOP),
  .HOST_STB(HOST_STB),
  .DMARQ(DMARQ),
  .D_OE_N(D_OE_N),
  .DEV_STB_OUT(DEV_STB_OUT),
  .DEV_STB_OE_N(DEV_STB_OE_N),
  .RX_VALID(RX_VALID),
  .BURST_DONE(BURST_DONE)
);
